// >>> logic/usbtx_sched.sv
// Host transmit endpoint scheduler: register bank, APB slave and frame timers.
`timescale 1ns/1ps
module usbtx_sched
   import usbtx_pkg::*;
(
   input  wire logic              CORE_CLK_IN,
   input  wire logic              RESET_IN,
   input  wire logic              PSEL_IN,
   input  wire logic              PENABLE_IN,
   input  wire logic              PWRITE_IN,
   input  wire logic [7:0]        PADDR_IN,
   input  wire logic [31:0]       PWDATA_IN,
   output logic       [31:0]       PRDATA_OUT,
   output logic                    PREADY_OUT,
   output logic                    PSLVERR_OUT,
   input  wire logic              SOF_IN,
   input  wire usbtx_hs_s         HANDSHAKE_IN,
   output logic       [NUM_EP-1:0] POLL_DUE_OUT,
   output logic       [NUM_EP-1:0] EP_HALT_OUT,
   output logic                    IRQ_OUT
);

   // ********************************************************************
   // Register storage.
   // ********************************************************************
   logic [7:0]        tx_type [1:NUM_EP-1];
   logic [7:0]        next_tx_type [1:NUM_EP-1];
   logic [7:0]        tx_intvl [1:NUM_EP-1];
   logic [7:0]        next_tx_intvl [1:NUM_EP-1];
   logic [4:0]        ep0_limit;
   logic [4:0]        next_ep0_limit;

   logic [31:0]       next_rdata;
   logic              next_ready;
   logic              next_err;

   logic              setup;
   logic              wr_done;
   logic              addr_ok;
   logic              hit_ep;
   logic              hit_ep0;
   logic              hit_stat;
   logic              hit_clr;
   logic              hit_en;
   logic              mapped;
   logic [7:0]        ep_off;
   logic [1:0]        ep_idx;

   logic [NUM_EP-1:0] irq_enable;
   logic [NUM_EP-1:0] timeout;
   usbtx_tcfg_s       cfg [NUM_EP];

   // ********************************************************************
   // Address decode.
   // ********************************************************************
   always_comb begin
      setup    = PSEL_IN && !PENABLE_IN;
      wr_done  = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
      addr_ok  = (PADDR_IN[1:0] == 2'h0);
      ep_off   = PADDR_IN - OFF_EP_BASE;
      ep_idx   = ep_off[4:3] + 2'h1;
      hit_ep   = addr_ok && (PADDR_IN >= OFF_EP_BASE) && (PADDR_IN < OFF_EP_END);
      hit_ep0  = (PADDR_IN == OFF_EP0_NAK);
      hit_stat = (PADDR_IN == OFF_IRQ_STATUS);
      hit_clr  = (PADDR_IN == OFF_IRQ_CLEAR);
      hit_en   = (PADDR_IN == OFF_IRQ_ENABLE);
      mapped   = hit_ep || hit_ep0 || hit_stat || hit_clr || hit_en;
   end

   // ********************************************************************
   // Register writes.
   // ********************************************************************
   always_comb begin
      next_ep0_limit = ep0_limit;
      if (wr_done && hit_ep0) begin
         next_ep0_limit = PWDATA_IN[4:0];
      end
      for (int i = 1; i < NUM_EP; i++) begin
         next_tx_type[i]  = tx_type[i];
         next_tx_intvl[i] = tx_intvl[i];
         if (wr_done && hit_ep && ep_idx == i[1:0]) begin
            if (ep_off[2]) begin
               next_tx_intvl[i] = PWDATA_IN[7:0];
            end else begin
               next_tx_type[i] = PWDATA_IN[7:0];
            end
         end
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (RESET_IN) begin
         ep0_limit <= REG_RESET[4:0];
         for (int i = 1; i < NUM_EP; i++) begin
            tx_type[i]  <= REG_RESET;
            tx_intvl[i] <= REG_RESET;
         end
      end else begin
         ep0_limit <= next_ep0_limit;
         for (int i = 1; i < NUM_EP; i++) begin
            tx_type[i]  <= next_tx_type[i];
            tx_intvl[i] <= next_tx_intvl[i];
         end
      end
   end

   // ********************************************************************
   // APB answer: read data and error are captured in the setup cycle.
   // ********************************************************************
   always_comb begin
      next_ready = setup;
      next_err   = setup && !mapped;
      next_rdata = PRDATA_OUT;
      if (setup) begin
         next_rdata = 32'h0000_0000;
         if (!PWRITE_IN) begin
            if (hit_ep0) begin
               next_rdata = {27'h0, ep0_limit};
            end else if (hit_stat) begin
               next_rdata = {{(32 - NUM_EP){1'b0}}, EP_HALT_OUT};
            end else if (hit_en) begin
               next_rdata = {{(32 - NUM_EP){1'b0}}, irq_enable};
            end else if (hit_ep) begin
               next_rdata[7:0] = ep_off[2] ? tx_intvl[ep_idx] : tx_type[ep_idx];
            end
         end
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (RESET_IN) begin
         PRDATA_OUT  <= 32'h0000_0000;
         PREADY_OUT  <= 1'b0;
         PSLVERR_OUT <= 1'b0;
      end else begin
         PRDATA_OUT  <= next_rdata;
         PREADY_OUT  <= next_ready;
         PSLVERR_OUT <= next_err;
      end
   end

   // ********************************************************************
   // Per-endpoint timing.
   // ********************************************************************
   for (genvar g = 0; g < NUM_EP; g++) begin : gen_ep
      logic hs_hit;

      if (g == 0) begin : gen_ep0
         assign cfg[g] = usbtx_decode(SPD_HIGH, TRANSFER_PROTOCOL_CONTROL, {3'h0, ep0_limit},
                                      1'b1);
      end else begin : gen_epn
         assign cfg[g] = usbtx_decode(tx_type[g][SPEED_POS +: 2],
                                      tx_type[g][TRANSFER_PROTOCOL_POS +: 2],
                                      tx_intvl[g], 1'b0);

         a_illegal_speed: assert property (@(posedge CORE_CLK_IN)
            disable iff (RESET_IN)
            (tx_type[g][SPEED_POS +: 2] == SPD_ILLEGAL) |-> !cfg[g].enable)
            else $error("Illegal speed code left the endpoint timer running.");

         a_bulk_nak_mode: assert property (@(posedge CORE_CLK_IN)
            disable iff (RESET_IN)
            (tx_type[g][TRANSFER_PROTOCOL_POS +: 2] == TRANSFER_PROTOCOL_BULK && cfg[g].enable)
            |-> cfg[g].nak_mode)
            else $error("Bulk protocol did not select NAK timeout mode.");

         a_bulk_window: assert property (@(posedge CORE_CLK_IN)
            disable iff (RESET_IN)
            (tx_type[g][TRANSFER_PROTOCOL_POS +: 2] == TRANSFER_PROTOCOL_BULK
             && tx_type[g][SPEED_POS +: 2] == SPD_FULL
             && tx_intvl[g] >= 8'h02 && tx_intvl[g] <= 8'h10)
            |-> cfg[g].enable && cfg[g].period == (16'h0001 << (tx_intvl[g] - 8'h01)))
            else $error("Bulk NAK window does not match the interval value.");

         a_bulk_disable: assert property (@(posedge CORE_CLK_IN)
            disable iff (RESET_IN)
            (tx_type[g][TRANSFER_PROTOCOL_POS +: 2] == TRANSFER_PROTOCOL_BULK && tx_intvl[g] <= 8'h01)
            |-> !cfg[g].enable)
            else $error("Bulk NAK timeout active with a value of 0 or 1.");

         a_intr_frames: assert property (@(posedge CORE_CLK_IN)
            disable iff (RESET_IN)
            (tx_type[g][TRANSFER_PROTOCOL_POS +: 2] == TRANSFER_PROTOCOL_INTR
             && tx_type[g][SPEED_POS +: 2] == SPD_LOW && tx_intvl[g] != 8'h00)
            |-> cfg[g].enable && !cfg[g].nak_mode
                && cfg[g].period == {8'h00, tx_intvl[g]})
            else $error("Low speed interrupt period is not m frames.");

         a_intr_micro: assert property (@(posedge CORE_CLK_IN)
            disable iff (RESET_IN)
            (tx_type[g][TRANSFER_PROTOCOL_POS +: 2] == TRANSFER_PROTOCOL_INTR
             && tx_type[g][SPEED_POS +: 2] == SPD_HIGH
             && tx_intvl[g] >= 8'h01 && tx_intvl[g] <= 8'h10)
            |-> cfg[g].period == (16'h0001 << (tx_intvl[g] - 8'h01)))
            else $error("High speed interrupt period is not a power of two.");

         a_iso_period: assert property (@(posedge CORE_CLK_IN)
            disable iff (RESET_IN)
            (tx_type[g][TRANSFER_PROTOCOL_POS +: 2] == TRANSFER_PROTOCOL_ISO
             && tx_type[g][SPEED_POS +: 2] == SPD_FULL
             && tx_intvl[g] >= 8'h01 && tx_intvl[g] <= 8'h10)
            |-> cfg[g].enable && !cfg[g].nak_mode
                && cfg[g].period == (16'h0001 << (tx_intvl[g] - 8'h01)))
            else $error("Isochronous period does not match the interval value.");

         a_type_write: assert property (@(posedge CORE_CLK_IN)
            disable iff (RESET_IN)
            (wr_done && hit_ep && !ep_off[2] && ep_idx == g)
            |=> tx_type[g] == $past(PWDATA_IN[7:0]))
            else $error("Type register did not take the written value.");

         a_interval_write: assert property (@(posedge CORE_CLK_IN)
            disable iff (RESET_IN)
            (wr_done && hit_ep && ep_off[2] && ep_idx == g)
            |=> tx_intvl[g] == $past(PWDATA_IN[7:0]))
            else $error("Interval register did not take the written value.");
      end

      assign hs_hit = HANDSHAKE_IN.valid && (HANDSHAKE_IN.ep == g);

      usbtx_frame_timer u_timer (
         .clk_in      (CORE_CLK_IN),
         .reset_in    (RESET_IN),
         .sof_in      (SOF_IN),
         .cfg_in      (cfg[g]),
         .hs_valid_in (hs_hit),
         .hs_nak_in   (HANDSHAKE_IN.nak),
         .hold_in     (EP_HALT_OUT[g]),
         .due_out     (POLL_DUE_OUT[g]),
         .timeout_out (timeout[g])
      );

      a_halt_follows: assert property (@(posedge CORE_CLK_IN)
         disable iff (RESET_IN)
         timeout[g] |=> EP_HALT_OUT[g])
         else $error("Endpoint not halted after a NAK timeout.");

      a_halted_quiet: assert property (@(posedge CORE_CLK_IN)
         disable iff (RESET_IN)
         EP_HALT_OUT[g] |=> !timeout[g])
         else $error("A halted endpoint raised another timeout.");

      a_nak_no_poll: assert property (@(posedge CORE_CLK_IN)
         disable iff (RESET_IN)
         cfg[g].nak_mode |=> !POLL_DUE_OUT[g])
         else $error("A NAK timeout endpoint raised a polling pulse.");
   end

   // ********************************************************************
   // Halt status and interrupt.
   // ********************************************************************
   usbtx_irq_ctrl u_irq (
      .clk_in       (CORE_CLK_IN),
      .reset_in     (RESET_IN),
      .event_in     (timeout),
      .clear_wr_in  (wr_done && hit_clr),
      .enable_wr_in (wr_done && hit_en),
      .wdata_in     (PWDATA_IN[NUM_EP-1:0]),
      .status_out   (EP_HALT_OUT),
      .enable_out   (irq_enable),
      .irq_out      (IRQ_OUT)
   );

   a_ep0_window: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (ep0_limit >= 5'h02 && ep0_limit <= 5'h10)
      |-> cfg[0].enable && cfg[0].nak_mode
          && cfg[0].period == (16'h0001 << (ep0_limit - 5'h01)))
      else $error("Endpoint 0 NAK window does not match the limit value.");

   a_ep0_disable: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (ep0_limit <= 5'h01) |-> !cfg[0].enable)
      else $error("Endpoint 0 NAK timeout active with a value of 0 or 1.");

   a_reserved_zero: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (setup && !PWRITE_IN && PADDR_IN == OFF_EP0_NAK) |=> PRDATA_OUT[31:5] == 27'h0)
      else $error("Reserved bits of the endpoint 0 limit register read nonzero.");

   a_apb_answer: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      setup |=> PREADY_OUT ##1 !PREADY_OUT)
      else $error("APB answer did not come in the first access cycle.");

   a_ready_only: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      !setup |=> !PREADY_OUT)
      else $error("Ready rose without a setup cycle.");

   a_unmapped_error: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (setup && !mapped) |=> PSLVERR_OUT && PREADY_OUT && PRDATA_OUT == 32'h0000_0000)
      else $error("Unmapped access did not end in an error with zero data.");

   a_limit_write: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (wr_done && hit_ep0) |=> ep0_limit == $past(PWDATA_IN[4:0]))
      else $error("Endpoint 0 limit did not take the written value.");

   a_ep0_no_poll: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      !POLL_DUE_OUT[0])
      else $error("Endpoint 0 raised a polling pulse.");

   a_halt_sticky: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      !(wr_done && hit_clr) |=> (EP_HALT_OUT & $past(EP_HALT_OUT)) == $past(EP_HALT_OUT))
      else $error("A halt bit fell without a clear write.");

   a_irq_level: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      IRQ_OUT == |(EP_HALT_OUT & irq_enable))
      else $error("Interrupt line does not follow the enabled status.");

endmodule

// >>> common/usbtx_pkg.sv
// Shared constants, types and timing decode for the host transmit scheduler.
// Function
// - Target speed field codes high as 1h, full 2h, low 3h; zero illegal.
// - Protocol bits 5-4 select control 0, isochronous 1h, bulk 2h, interrupt 3h.
// - Endpoint 0 limit m in 2..16 gives a timeout of 2^(m-1) frames.
// - NAKs lasting more frames than the limit halt the affected endpoint.
// - Limit value 0 or 1 disables the NAK timeout on endpoint 0 and bulk.
// - Low or full speed interrupt interval m in 1..255 polls every m frames.
// - High speed interrupt interval m in 1..16 polls every 2^(m-1) microframes.
// - Full or high speed isochronous interval m in 1..16 gives a 2^(m-1) frame polling period; low speed never polls.
// - Full or high speed bulk interval m in 2..16 sets a 2^(m-1) frame NAK timeout window; low speed has none.
// - Each endpoint above 0 has its own interval register; endpoint 0 its limit.
package usbtx_pkg;

   // ********************************************************************
   // Sizes and register map.
   // ********************************************************************
   localparam int         NUM_EP         = 4;
   localparam logic [7:0] OFF_EP0_NAK    = 8'h00;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h04;
   localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h08;
   localparam logic [7:0] OFF_IRQ_ENABLE = 8'h0c;
   localparam logic [7:0] OFF_EP_BASE    = 8'h10;
   localparam logic [7:0] OFF_EP_END     = 8'h28;
   localparam logic [7:0] REG_RESET      = 8'h00;

   // ********************************************************************
   // Field positions and codes.
   // ********************************************************************
   localparam int         SPEED_POS      = 6;
   localparam int         TRANSFER_PROTOCOL_POS       = 4;
   localparam int         TEP_POS        = 0;
   localparam logic [1:0] SPD_ILLEGAL    = 2'h0;
   localparam logic [1:0] SPD_HIGH       = 2'h1;
   localparam logic [1:0] SPD_FULL       = 2'h2;
   localparam logic [1:0] SPD_LOW        = 2'h3;

   typedef enum logic [1:0] {
      TRANSFER_PROTOCOL_CONTROL,
      TRANSFER_PROTOCOL_ISO,
      TRANSFER_PROTOCOL_BULK,
      TRANSFER_PROTOCOL_INTR
   } usbtx_transfer_protocol_e;

   // ********************************************************************
   // Interval value limits on the register value m, not on frame or microframe counts.
   // ********************************************************************
   localparam logic [7:0] M_POLL_MIN     = 8'h01;
   localparam logic [7:0] M_NAK_MIN      = 8'h02;
   localparam logic [7:0] M_EXP_MAX      = 8'h10;

   typedef struct packed {
      logic       valid;
      logic [1:0] ep;
      logic       nak;
   } usbtx_hs_s;

   typedef struct packed {
      logic        enable;
      logic        nak_mode;
      logic [15:0] period;
   } usbtx_tcfg_s;

   function automatic usbtx_tcfg_s usbtx_decode(input logic [1:0] speed,
                                                input logic [1:0] transfer_protocol,
                                                input logic [7:0] m,
                                                input logic       ep0);
      usbtx_tcfg_s c;
      logic [15:0] pow;
      logic        exp_ok;
      logic        nak_ok;
      c      = '0;
      pow    = 16'h0001 << (m - 8'h01);
      exp_ok = (m >= M_POLL_MIN) && (m <= M_EXP_MAX);
      nak_ok = (m >= M_NAK_MIN) && (m <= M_EXP_MAX);
      if (ep0) begin
         if (nak_ok) begin
            c = '{1'b1, 1'b1, pow};
         end
      end else if (speed != SPD_ILLEGAL) begin
         case (usbtx_transfer_protocol_e'(transfer_protocol))
            TRANSFER_PROTOCOL_ISO: begin
               if (speed != SPD_LOW && exp_ok) c = '{1'b1, 1'b0, pow};
            end
            TRANSFER_PROTOCOL_INTR: begin
               if (speed == SPD_HIGH) begin
                  if (exp_ok) c = '{1'b1, 1'b0, pow};
               end else if (m >= M_POLL_MIN) begin
                  c = '{1'b1, 1'b0, {8'h00, m}};
               end
            end
            TRANSFER_PROTOCOL_BULK: begin
               if (speed != SPD_LOW && nak_ok) c = '{1'b1, 1'b1, pow};
            end
            default: c = '0;
         endcase
      end
      return c;
   endfunction

endpackage

// >>> logic/usbtx_frame_timer.sv
// Per-endpoint frame counter for polling periods and NAK timeouts.
`timescale 1ns/1ps
module usbtx_frame_timer
   import usbtx_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic        sof_in,
   input  wire usbtx_tcfg_s cfg_in,
   input  wire logic        hs_valid_in,
   input  wire logic        hs_nak_in,
   input  wire logic        hold_in,
   output logic             due_out,
   output logic             timeout_out
);

   logic [15:0] count;
   logic [15:0] next_count;
   logic        nak_active;
   logic        next_nak_active;
   logic        next_due;
   logic        next_timeout;

   // ********************************************************************
   // Counting.
   // ********************************************************************
   always_comb begin
      next_count      = count;
      next_nak_active = nak_active;
      next_due        = 1'b0;
      next_timeout    = 1'b0;
      if (!cfg_in.enable || hold_in) begin
         next_count      = '0;
         next_nak_active = 1'b0;
      end else if (cfg_in.nak_mode) begin
         if (hs_valid_in && !hs_nak_in) begin
            next_count      = '0;
            next_nak_active = 1'b0;
         end else begin
            if (hs_valid_in) next_nak_active = 1'b1;
            if (sof_in && nak_active) begin
               if (count >= cfg_in.period) begin
                  next_timeout = 1'b1;
                  next_count   = '0;
               end else begin
                  next_count = count + 16'h0001;
               end
            end
         end
      end else if (sof_in) begin
         if (count >= cfg_in.period - 16'h0001) begin
            next_due   = 1'b1;
            next_count = '0;
         end else begin
            next_count = count + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         count       <= '0;
         nak_active  <= 1'b0;
         due_out     <= 1'b0;
         timeout_out <= 1'b0;
      end else begin
         count       <= next_count;
         nak_active  <= next_nak_active;
         due_out     <= next_due;
         timeout_out <= next_timeout;
      end
   end

   a_nak_restart: assert property (@(posedge clk_in) disable iff (reset_in)
      (cfg_in.enable && cfg_in.nak_mode && !hold_in && hs_valid_in && !hs_nak_in)
      |=> (count == 16'h0000) && !nak_active)
      else $error("NAK counter did not restart on a non-NAK handshake.");

   a_timeout_cause: assert property (@(posedge clk_in) disable iff (reset_in)
      timeout_out |-> $past(nak_active) && $past(sof_in) && $past(cfg_in.nak_mode))
      else $error("Timeout raised without a persisting NAK at a frame start.");

endmodule

// >>> logic/usbtx_irq_ctrl.sv
// Sticky event status, enable mask and level interrupt.
`timescale 1ns/1ps
module usbtx_irq_ctrl
   import usbtx_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              reset_in,
   input  wire logic [NUM_EP-1:0] event_in,
   input  wire logic              clear_wr_in,
   input  wire logic              enable_wr_in,
   input  wire logic [NUM_EP-1:0] wdata_in,
   output logic       [NUM_EP-1:0] status_out,
   output logic       [NUM_EP-1:0] enable_out,
   output logic                    irq_out
);

   logic [NUM_EP-1:0] next_status;
   logic [NUM_EP-1:0] next_enable;

   always_comb begin
      next_status = status_out & ~(clear_wr_in ? wdata_in : '0);
      next_status = next_status | event_in;
      next_enable = enable_wr_in ? wdata_in : enable_out;
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         status_out <= '0;
         enable_out <= '0;
         irq_out    <= 1'b0;
      end else begin
         status_out <= next_status;
         enable_out <= next_enable;
         irq_out    <= |(next_status & next_enable);
      end
   end

   a_set_wins: assert property (@(posedge clk_in) disable iff (reset_in)
      (event_in != '0) |=> ((status_out & $past(event_in)) == $past(event_in)))
      else $error("An event was lost against a simultaneous clear.");

endmodule

// >>> verif/usbtx_target_model.sv
// Behavioural downstream target that answers host tokens with handshakes.
`timescale 1ns/1ps
module usbtx_target_model
   import usbtx_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       token_in,
   input  wire logic [1:0] ep_in,
   input  wire logic [3:0] nak_in,
   output usbtx_hs_s       hs_out
);
   // ****************************************************************
   // Answer one cycle after each token; idle fields toggle each cycle.
   // ****************************************************************
   initial begin
      hs_out = '0;
      forever @(posedge clk_in) begin
         hs_out.valid <= token_in;
         hs_out.ep    <= token_in ? ep_in : ~hs_out.ep;
         hs_out.nak   <= token_in ? nak_in[ep_in] : ~hs_out.nak;
      end
   end
endmodule

// >>> verif/testbench.sv
// Self-checking testbench for the host transmit endpoint scheduler.
`timescale 1ns/1ps
module testbench;
   import usbtx_pkg::*;
   logic              clk;
   logic              rst;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [7:0]        paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              sof;
   logic              irq;
   logic              token;
   logic [1:0]        tok_ep;
   logic [3:0]        nak_map;
   usbtx_hs_s         hs;
   logic [NUM_EP-1:0] due;
   logic [NUM_EP-1:0] halt;
   logic [31:0]       rd;
   logic              err;
   int                errors;
   int                check_count;
   int                cycles;
   int                due_cnt;

   // ****************************************************************
   // Clock, design and partner.
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   usbtx_sched dut (.CORE_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SOF_IN(sof), .HANDSHAKE_IN(hs),
      .POLL_DUE_OUT(due), .EP_HALT_OUT(halt), .IRQ_OUT(irq));
   usbtx_target_model target (.clk_in(clk), .token_in(token), .ep_in(tok_ep),
      .nak_in(nak_map), .hs_out(hs));

   // ****************************************************************
   // Shared tasks.
   // ****************************************************************
   task automatic end_sim();
      if (errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic frames(input logic [1:0] ep, input logic send, input int n);
      repeat (n) begin
         @(posedge clk);
         token  <= send;
         tok_ep <= ep;
         @(posedge clk);
         token <= 1'b0;
         @(posedge clk);
         sof <= 1'b1;
         @(posedge clk);
         sof <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
   always @(posedge clk) begin
      if (due[2] === 1'b1) due_cnt++;
      cycles++;
      if (cycles == 20000) begin
         errors++;
         end_sim();
      end
   end

   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task automatic test_reset();
      apb(1'b0, 8'h00, 32'h0);
      check("limit reset", rd, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      check("type reset", rd, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      check("interval reset", rd, 32'h0);
      apb(1'b1, 8'h40, 32'hff);
      check("unmapped error", {31'h0, err}, 32'h1);
      apb(1'b0, 8'h40, 32'h0);
      check("unmapped read", rd, 32'h0);
   endtask
   task automatic test_regs();
      apb(1'b1, 8'h00, 32'hff);
      apb(1'b0, 8'h00, 32'h0);
      check("limit reserved", rd, 32'h1f);
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, 8'h20, {24'h0, c[1:0], c[3:2], c[3:0]});
         apb(1'b0, 8'h20, 32'h0);
         check("type fields", rd, {24'h0, c[1:0], c[3:2], c[3:0]});
      end
      apb(1'b1, 8'h14, 32'ha5);
      apb(1'b0, 8'h00, 32'h0);
      check("limit apart", rd, 32'h1f);
      apb(1'b0, 8'h14, 32'h0);
      check("interval", rd, 32'ha5);
   endtask
   task automatic poll(input logic [1:0] s, input logic [1:0] p, input logic [7:0] m,
                       input int n, input int exp);
      apb(1'b1, 8'h1c, 32'h0);
      apb(1'b1, 8'h18, {24'h0, s, p, 4'h2});
      apb(1'b1, 8'h1c, {24'h0, m});
      due_cnt = 0;
      frames(2'h2, 1'b0, n);
      check("poll pulses", due_cnt, exp);
   endtask
   task automatic test_nak();
      apb(1'b1, 8'h10, 32'ha1);
      apb(1'b1, 8'h14, 32'h02);
      apb(1'b1, 8'h0c, 32'h02);
      nak_map <= 4'hf;
      frames(2'h1, 1'b1, 2);
      check("halt early", halt, 4'h0);
      nak_map <= 4'h0;
      frames(2'h1, 1'b1, 1);
      nak_map <= 4'hf;
      frames(2'h1, 1'b1, 2);
      check("halt restart", halt, 4'h0);
      frames(2'h1, 1'b1, 1);
      check("bulk halt", halt, 4'h2);
      check("irq set", irq, 1'b1);
      apb(1'b0, 8'h04, 32'h0);
      check("status", rd, 32'h2);
      apb(1'b1, 8'h08, 32'h2);
      apb(1'b0, 8'h04, 32'h0);
      check("status clear", rd, 32'h0);
      check("irq clear", irq, 1'b0);
      apb(1'b1, 8'h14, 32'h01);
      frames(2'h1, 1'b1, 6);
      check("bulk off", halt, 4'h0);
   endtask
   task automatic test_ep0();
      apb(1'b1, 8'h00, 32'h02);
      frames(2'h0, 1'b1, 3);
      check("ep0 halt", halt, 4'h1);
      check("irq masked", irq, 1'b0);
      apb(1'b1, 8'h08, 32'h1);
      apb(1'b1, 8'h00, 32'h00);
      frames(2'h0, 1'b1, 6);
      check("ep0 off", halt, 4'h0);
   endtask

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, sof, token} = '0;
      paddr = '0;
      pwdata = '0;
      tok_ep = '0;
      nak_map = '0;
      errors = 0;
      check_count = 0;
      cycles = 0;
      due_cnt = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      test_reset();
      test_regs();
      poll(SPD_FULL, 2'h3, 8'h03, 9, 3);
      poll(SPD_LOW, 2'h3, 8'h01, 3, 3);
      poll(SPD_HIGH, 2'h3, 8'h03, 8, 2);
      poll(SPD_FULL, 2'h1, 8'h02, 8, 4);
      poll(SPD_HIGH, 2'h1, 8'h01, 4, 4);
      poll(SPD_LOW, 2'h1, 8'h01, 4, 0);
      poll(SPD_ILLEGAL, 2'h3, 8'h01, 4, 0);
      poll(SPD_FULL, 2'h0, 8'h01, 4, 0);
      test_nak();
      test_ep0();
      end_sim();
   end
endmodule
